// file: logic/masc_pkg.sv
// constants shared by the maximum-address security command block
// assumes a single core clock and an active-low asynchronous reset
`default_nettype none
package masc_pkg;
  localparam logic [7:0] OPC_SET_MAX = 8'hF9;
  localparam logic [7:0] OPC_SET_MAX_EXT = 8'h37;
  localparam logic [7:0] FEAT_SET_PASSWORD = 8'h01;
  localparam logic [7:0] FEAT_LOCK = 8'h02;
  localparam logic [7:0] FEAT_UNLOCK = 8'h03;
  localparam logic [7:0] FEAT_FREEZE = 8'h04;
  // sector-count bit that asks for a persistent limit
  localparam int NV_BIT = 0;
  localparam logic [2:0] UNLOCK_TRIES_RST = 3'h5;
  localparam logic [47:0] LBA28_LIMIT = 48'h00000FFFFFFF;
  localparam logic [7:0] WORDS_PER_SECTOR = 8'hFF;
  localparam logic [7:0] PW_FIRST_WORD = 8'h01;
  localparam logic [7:0] PW_LAST_WORD = 8'h10;
  localparam int PW_WORDS = 16;
  // status bit positions
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DF = 5;
  localparam int ST_DRQ = 3;
  localparam int ST_COR = 2;
  localparam int ST_ERR = 0;
  // error bit position: aborted command
  localparam int ER_ABT = 2;
  localparam logic [7:0] STATUS_RST = 8'h40;
  localparam logic [7:0] ERROR_RST = 8'h00;
  typedef enum logic [1:0] {
    MASC_IDLE,
    MASC_DATA,
    MASC_DONE
  } masc_state_t;
endpackage : masc_pkg
`default_nettype wire

// file: logic/masc_pw_if.sv
// carrier between the command block and its password store
// assumes both ends share core_clk
`default_nettype none
interface masc_pw_if;
  logic wr_en;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctrl (output wr_en, output addr, output wdata, input rdata);
  modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface : masc_pw_if
`default_nettype wire

// file: logic/masc_pw_store.sv
// sixteen-word password store with registered read data
// assumes address and write strobe come from core_clk logic
`default_nettype none
module masc_pw_store (
  input wire logic core_clk,
  input wire logic rst_n,
  masc_pw_if.mem pw
);
  import masc_pkg::*;

  logic [15:0] mem_q [PW_WORDS];
  logic [15:0] rdata_q;

  // contents are not reset: a password written before rst_n is kept, and unlock compares against whatever is stored
  always_ff @(posedge core_clk) begin
    if (pw.wr_en) begin
      mem_q[pw.addr] <= pw.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= mem_q[pw.addr];
    end
  end

  assign pw.rdata = rdata_q;
endmodule : masc_pw_store
`default_nettype wire

// file: logic/masc_ctrl.sv
// maximum-address security command interpreter
// assumes commands arrive as one-cycle strobes from same-clock taskfile
// logic; reads of the native maximum are decoded outside and reported
//
// Functional notes
// - F9h with feature 03h is unlock
// - F9h after native read means set address
// - unlock takes password sector, compared to stored
// - mismatch aborts and decrements attempt counter
// - counter starts 5; zero rejects unlock
// - match unlocks; all subcommands then accepted
// - F9h feature 04h enters frozen state
// - frozen rejects address, password, lock, unlock
// - 37h must follow extended native read
// - set limit within capacity; abort accesses beyond
// - above 28-bit range updates words 103:100 only
// - within 28-bit range updates both word groups
// - abort ext set on listed conditions
// - second non-volatile ext set aborts until reset
// - sector-count bit 0 picks persistence
// - 48-bit limit split over current/previous bytes
// - locked rejects all but unlock and freeze
`default_nettype none
module masc_ctrl #(
  parameter logic [47:0] NATIVE_MAX_LBA = 48'h0000FFFFFFFF,
  parameter bit EXT_SUPPORTED = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_feature,
  input wire logic [7:0] cmd_count,
  input wire logic [3:0] cmd_head,
  input wire logic [23:0] cmd_lba_cur,
  input wire logic [23:0] cmd_lba_prev,
  input wire logic native_read_done,
  input wire logic native_read_ext_done,
  input wire logic address_offset_mode,
  input wire logic data_valid,
  input wire logic [15:0] data_word,
  input wire logic high_byte_readback_select,
  input wire logic access_valid,
  input wire logic [47:0] access_lba,
  output logic data_request,
  output logic cmd_done,
  output logic access_abort,
  output logic [7:0] command_completion_flags,
  output logic [7:0] command_error_flags,
  output logic [7:0] readback_sector_number,
  output logic [7:0] readback_cylinder_low,
  output logic [7:0] readback_cylinder_high,
  output logic [47:0] max_lba,
  output logic max_lba_nonvolatile,
  output logic [63:0] identify_words_103_100,
  output logic [31:0] identify_words_61_60,
  output logic locked,
  output logic frozen,
  output logic [2:0] unlock_tries_left
);
  import masc_pkg::*;

  masc_pw_if pw ();

  masc_pw_store u_store (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pw(pw)
  );

  // -----------------------------------------------------------------
  // command decode
  // -----------------------------------------------------------------
  masc_state_t state_q, state_d;
  logic after_native_q, after_native_ext_q;
  logic locked_q, frozen_q, hpa_q, nv_used_q, nv_q;
  logic [2:0] tries_q;
  logic [47:0] max_q;
  logic [63:0] idw_hi_q;
  logic [31:0] idw_lo_q;
  logic [7:0] status_q, error_q;
  logic [7:0] feat_q, word_idx_q;
  logic mismatch_q, cmp_pend_q, done_q;
  logic [15:0] word_dly_q;

  wire is_f9 = cmd_valid && cmd_opcode == OPC_SET_MAX;
  wire is_ext = cmd_valid && cmd_opcode == OPC_SET_MAX_EXT;
  wire f9_set_addr = is_f9 && after_native_q;
  wire f9_sub = is_f9 && !after_native_q;
  wire sub_pw = f9_sub && cmd_feature == FEAT_SET_PASSWORD;
  wire sub_lock = f9_sub && cmd_feature == FEAT_LOCK;
  wire sub_unlock = f9_sub && cmd_feature == FEAT_UNLOCK;
  wire sub_freeze = f9_sub && cmd_feature == FEAT_FREEZE;
  wire sub_other = f9_sub && !(sub_pw || sub_lock || sub_unlock
                               || sub_freeze);

  // 28-bit limit for the non-extended form
  wire [47:0] req28 = {20'h00000, cmd_head, cmd_lba_cur};
  // previous bytes carry 47:24, current bytes 23:0
  wire [47:0] req48 = {cmd_lba_prev, cmd_lba_cur};
  wire nv_req = cmd_count[NV_BIT];

  // frozen blocks everything, freeze included; locked allows unlock and freeze
  wire gate_ok = !frozen_q && !locked_q;
  wire set28_ok = gate_ok && req28 <= NATIVE_MAX_LBA;
  wire ext_ok = EXT_SUPPORTED && after_native_ext_q && gate_ok
                && !hpa_q && req48 <= NATIVE_MAX_LBA
                && !(nv_req && (nv_used_q || address_offset_mode));
  wire unlock_ok = !frozen_q && tries_q != 3'h0;
  wire pw_ok = gate_ok;
  wire lock_ok = gate_ok;
  wire freeze_ok = !frozen_q;

  // -----------------------------------------------------------------
  // password data phase
  // -----------------------------------------------------------------
  wire in_pw = word_idx_q >= PW_FIRST_WORD && word_idx_q <= PW_LAST_WORD;
  wire last_word = data_valid && word_idx_q == WORDS_PER_SECTOR;
  wire feat_unlock = feat_q == FEAT_UNLOCK;

  assign pw.addr = 4'(word_idx_q - PW_FIRST_WORD);
  assign pw.wr_en = state_q == MASC_DATA && data_valid && in_pw
                    && !feat_unlock;
  assign pw.wdata = data_word;

  always_comb begin
    state_d = state_q;
    case (state_q)
      MASC_IDLE: begin
        if ((sub_unlock && unlock_ok) || (sub_pw && pw_ok)) begin
          state_d = MASC_DATA;
        end
      end
      MASC_DATA: begin
        if (last_word) begin
          state_d = MASC_DONE;
        end
      end
      MASC_DONE: begin
        // one cycle so the final compare lands
        state_d = MASC_IDLE;
      end
      default: state_d = MASC_IDLE;
    endcase
  end

  // immediate-completion outcome of a command taken in idle
  wire idle_take = state_q == MASC_IDLE && (is_f9 || is_ext);
  wire idle_finish = idle_take && state_d == MASC_IDLE;
  wire idle_abort = (sub_unlock && !unlock_ok) || (sub_pw && !pw_ok)
                    || (sub_lock && !lock_ok) || (sub_freeze && !freeze_ok)
                    || sub_other || (f9_set_addr && !set28_ok)
                    || (is_ext && !ext_ok);
  wire unlock_fail = feat_unlock && (mismatch_q || cmp_pend_q
                     && word_dly_q != pw.rdata);
  wire data_finish = state_q == MASC_DONE;
  wire data_abort = unlock_fail;

  // -----------------------------------------------------------------
  // state registers
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= MASC_IDLE;
      word_idx_q <= 8'h00;
      feat_q <= 8'h00;
      mismatch_q <= 1'b0;
      cmp_pend_q <= 1'b0;
      word_dly_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      cmp_pend_q <= state_q == MASC_DATA && data_valid && in_pw;
      word_dly_q <= data_word;
      if (idle_take) begin
        feat_q <= cmd_feature;
        word_idx_q <= 8'h00;
        mismatch_q <= 1'b0;
      end else begin
        if (state_q == MASC_DATA && data_valid) begin
          word_idx_q <= word_idx_q + 8'h01;
        end
        if (cmp_pend_q && word_dly_q != pw.rdata) begin
          mismatch_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      after_native_q <= 1'b0;
      after_native_ext_q <= 1'b0;
    end else begin
      // any later command breaks the "immediately preceded" chain
      after_native_q <= native_read_done
                        || (after_native_q && !cmd_valid);
      after_native_ext_q <= native_read_ext_done
                            || (after_native_ext_q && !cmd_valid);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      locked_q <= 1'b0;
      frozen_q <= 1'b0;
      tries_q <= UNLOCK_TRIES_RST;
    end else begin
      if (idle_take && sub_lock && lock_ok) begin
        locked_q <= 1'b1;
      end
      if (idle_take && sub_freeze && freeze_ok) begin
        frozen_q <= 1'b1;
        locked_q <= 1'b0;
      end
      if (data_finish && feat_unlock) begin
        if (unlock_fail) begin
          tries_q <= tries_q - 3'h1;
        end else begin
          locked_q <= 1'b0;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // limit and identify words
  // -----------------------------------------------------------------
  function automatic logic [31:0] words_lo(input logic [47:0] lba);
    words_lo = (lba <= LBA28_LIMIT) ? lba[31:0] : LBA28_LIMIT[31:0];
  endfunction : words_lo

  wire take_ext = idle_take && is_ext && ext_ok;
  wire take_28 = idle_take && f9_set_addr && set28_ok;
  wire [47:0] new_max = take_ext ? req48 : req28;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      max_q <= NATIVE_MAX_LBA;
      idw_hi_q <= {16'h0000, NATIVE_MAX_LBA};
      idw_lo_q <= words_lo(NATIVE_MAX_LBA);
      hpa_q <= 1'b0;
      nv_used_q <= 1'b0;
      nv_q <= 1'b0;
    end else if (take_ext || take_28) begin
      max_q <= new_max;
      idw_hi_q <= {16'h0000, new_max};
      if (new_max <= LBA28_LIMIT) begin
        idw_lo_q <= new_max[31:0];
      end
      if (take_28) begin
        hpa_q <= 1'b1;
      end
      if (take_ext) begin
        nv_q <= nv_req;
        nv_used_q <= nv_used_q || nv_req;
      end
    end
  end

  // -----------------------------------------------------------------
  // completion flags
  // -----------------------------------------------------------------
  wire finish = idle_finish || data_finish;
  wire aborted = idle_finish ? idle_abort : data_abort;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= STATUS_RST;
      error_q <= ERROR_RST;
      done_q <= 1'b0;
    end else begin
      done_q <= finish;
      if (finish) begin
        status_q <= 8'h00;
        status_q[ST_RDY] <= 1'b1;
        status_q[ST_ERR] <= aborted;
        error_q <= 8'h00;
        error_q[ER_ABT] <= aborted;
      end else if (state_d == MASC_DATA) begin
        status_q[ST_DRQ] <= 1'b1;
      end
    end
  end

  assign data_request = state_q == MASC_DATA;
  assign cmd_done = done_q;
  assign command_completion_flags = status_q;
  assign command_error_flags = error_q;
  assign access_abort = access_valid && access_lba > max_q;
  // readback split selected by the high byte select
  assign readback_sector_number = high_byte_readback_select ?
                                  max_q[31:24] : max_q[7:0];
  assign readback_cylinder_low = high_byte_readback_select ?
                                 max_q[39:32] : max_q[15:8];
  assign readback_cylinder_high = high_byte_readback_select ?
                                  max_q[47:40] : max_q[23:16];
  assign max_lba = max_q;
  assign max_lba_nonvolatile = nv_q;
  assign identify_words_103_100 = idw_hi_q;
  assign identify_words_61_60 = idw_lo_q;
  assign locked = locked_q;
  assign frozen = frozen_q;
  assign unlock_tries_left = tries_q;
endmodule : masc_ctrl
`default_nettype wire

// file: verification/masc_asserts.sv
// port checks for the max-address command block
// bound onto masc_ctrl; one clock, reset active low
`default_nettype none
module masc_asserts
  import masc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_feature,
  input wire logic native_read_done,
  input wire logic native_read_ext_done,
  input wire logic access_valid,
  input wire logic [47:0] access_lba,
  input wire logic data_request,
  input wire logic cmd_done,
  input wire logic access_abort,
  input wire logic [7:0] command_completion_flags,
  input wire logic [7:0] command_error_flags,
  input wire logic [47:0] max_lba,
  input wire logic [63:0] identify_words_103_100,
  input wire logic [31:0] identify_words_61_60,
  input wire logic locked,
  input wire logic frozen,
  input wire logic [2:0] unlock_tries_left
);
  logic nat_q;
  logic natx_q;
  // a native read arms only the very next command
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nat_q <= 1'b0;
      natx_q <= 1'b0;
    end else begin
      nat_q <= native_read_done | (nat_q & ~cmd_valid);
      natx_q <= native_read_ext_done | (natx_q & ~cmd_valid);
    end
  end
  wire logic f9 = cmd_valid && cmd_opcode == OPC_SET_MAX && !data_request;
  wire logic unl = f9 && !nat_q && cmd_feature == FEAT_UNLOCK;
  wire logic unl_ok = unl && !frozen && unlock_tries_left != 3'h0;
  wire logic frz = f9 && frozen && (nat_q || cmd_feature != FEAT_FREEZE);
  wire logic xbad = cmd_valid && cmd_opcode == OPC_SET_MAX_EXT &&
    !data_request && (locked || frozen || !natx_q);
  wire logic big = max_lba > LBA28_LIMIT;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // flags and the done pulse land on the same edge; the pulse lasts one cycle
  sequence s_abort;
    cmd_done && command_error_flags == 8'h04 ##1 !cmd_done;
  endsequence
  property p_unlock; unl_ok |=> data_request; endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock opened no data phase");
  property p_spent; unl && unlock_tries_left == 3'h0 |=> s_abort; endproperty
  a_spent: assert property (p_spent)
    else $error("unlock with no tries left not refused");
  property p_frozen; frz |=> s_abort; endproperty
  a_frozen: assert property (p_frozen)
    else $error("command accepted while frozen");
  property p_ext; xbad |=> s_abort; endproperty
  a_ext: assert property (p_ext)
    else $error("extended set not refused");
  property p_access;
    access_abort == (access_valid && access_lba > max_lba);
  endproperty
  a_access: assert property (p_access)
    else $error("access abort wrong");
  property p_id; $changed(max_lba) |-> identify_words_103_100 == max_lba;
  endproperty
  a_id: assert property (p_id)
    else $error("long identify words not updated");
  property p_id_keep;
    $changed(max_lba) && big |-> $stable(identify_words_61_60);
  endproperty
  a_id_keep: assert property (p_id_keep)
    else $error("short identify words changed");
  property p_flags;
    cmd_done |-> (command_completion_flags & 8'hA5) ==
      {7'h00, command_error_flags[ER_ABT]} && !(command_error_flags & 8'hFB);
  endproperty
  a_flags: assert property (p_flags)
    else $error("completion flags wrong");
endmodule : masc_asserts
bind masc_ctrl masc_asserts i_masc_chk (.*);
`default_nettype wire

// file: verification/masc_host.sv
// host model: issues taskfile commands and the password sector
// assumes the completion handshake of the command block
`default_nettype none
module masc_host (
  input wire logic core_clk,
  input wire logic data_request,
  input wire logic cmd_done,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [7:0] cmd_feature,
  output logic [7:0] cmd_count,
  output logic [3:0] cmd_head,
  output logic [23:0] cmd_lba_cur,
  output logic [23:0] cmd_lba_prev,
  output logic native_read_done,
  output logic native_read_ext_done,
  output logic data_valid,
  output logic [15:0] data_word
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cmd_valid, native_read_done, native_read_ext_done, data_valid} = '0;
    {cmd_opcode, cmd_feature, cmd_count, cmd_head} = '0;
    {cmd_lba_cur, cmd_lba_prev, data_word} = '0;
  end
  // nat 1: plain native read first, 2: extended native read first
  task automatic send(input logic [7:0] op, ft, cn,
    input logic [47:0] lba, input logic [15:0] pw, input int nat);
    @(negedge core_clk);
    native_read_done = nat == 1;
    native_read_ext_done = nat == 2;
    if (nat != 0) @(negedge core_clk);
    {native_read_done, native_read_ext_done} = 2'h0;
    {cmd_opcode, cmd_feature, cmd_count} = {op, ft, cn};
    {cmd_head, cmd_lba_prev, cmd_lba_cur} = {lba[27:24], lba};
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    // one sector, words 1 to 16 carry the password
    for (int i = 0; i < 256 && data_request; i++) begin
      data_valid = 1'b1;
      data_word = (i > 0 && i < 17) ? pw ^ 16'(i) : 16'hA55A;
      @(negedge core_clk);
    end
    data_valid = 1'b0;
    // a released bus must not keep showing the last word
    data_word = ~data_word;
    for (int i = 0; i < 400 && !cmd_done; i++) @(negedge core_clk);
  endtask : send
endmodule : masc_host
`default_nettype wire

// file: verification/max_address_security_control_tb_top.sv
// bench for the max-address command block and its host model
// assumes a 100 MHz core clock; inputs change at the falling edge
`default_nettype none
module max_address_security_control_tb_top;
  import masc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, cmd_valid, native_read_done, native_read_ext_done;
  logic data_valid, data_request, cmd_done, access_abort, locked, frozen;
  logic address_offset_mode, high_byte_readback_select, access_valid;
  logic max_lba_nonvolatile;
  logic [7:0] cmd_opcode, cmd_feature, cmd_count, command_completion_flags;
  logic [7:0] command_error_flags, readback_sector_number;
  logic [7:0] readback_cylinder_low, readback_cylinder_high;
  logic [3:0] cmd_head;
  logic [2:0] unlock_tries_left;
  logic [15:0] data_word;
  logic [23:0] cmd_lba_cur, cmd_lba_prev;
  logic [31:0] identify_words_61_60;
  logic [47:0] access_lba, max_lba;
  logic [63:0] identify_words_103_100;
  int errors, cmp_count;
  localparam logic [15:0] PW = 16'hC3A1;
  localparam logic [47:0] L1 = 48'h00000ABCDEF0;
  localparam logic [47:0] L3 = 48'h000020000000;
  masc_ctrl i_dut (.*);
  masc_host i_host (.*);
  task automatic chk(input logic [63:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op, ft, cn, input logic [47:0] lba,
    input logic [15:0] pw, input int nat, input logic ab);
    i_host.send(op, ft, cn, lba, pw, nat);
    chk(cmd_done, 1'b1);
    chk(command_completion_flags, ab ? 8'h41 : 8'h40);
    chk(command_error_flags, ab ? 8'h04 : 8'h00);
  endtask : cmd
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    chk({frozen, locked, unlock_tries_left, max_lba},
      {5'h05, 48'h0000FFFFFFFF});
  endtask : do_reset
  task automatic complete_run;
    $display("compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // the run needs some 2k cycles; 25 times that is a hang
  initial begin
    #500us;
    errors++;
    complete_run();
  end
  initial begin
    {rst_n, address_offset_mode, high_byte_readback_select} = 3'h0;
    {access_valid, access_lba} = '0;
    do_reset();
    cmd(8'hF9, 8'h01, 8'h00, '0, PW, 0, 1'b0);
    cmd(8'hF9, 8'h02, 8'h00, '0, PW, 0, 1'b0);
    cmd(8'h37, 8'h00, 8'h00, L1, PW, 2, 1'b1);
    cmd(8'hF9, 8'h03, 8'h00, '0, ~PW, 0, 1'b1);
    chk({locked, unlock_tries_left}, 4'hC);
    cmd(8'hF9, 8'h03, 8'h00, '0, PW, 0, 1'b0);
    chk({locked, unlock_tries_left}, 4'h4);
    cmd(8'h37, 8'h00, 8'h01, L1, PW, 2, 1'b0);
    chk({max_lba_nonvolatile, max_lba}, {1'b1, L1});
    chk(identify_words_61_60, L1[31:0]);
    high_byte_readback_select = 1'b1;
    {access_valid, access_lba} = {1'b1, L1 + 48'h1};
    #1 chk({readback_cylinder_high, readback_cylinder_low,
      readback_sector_number}, L1[47:24]);
    chk(access_abort, 1'b1);
    @(negedge core_clk);
    high_byte_readback_select = 1'b0;
    access_lba = L1;
    #1 chk({readback_cylinder_high, readback_cylinder_low,
      readback_sector_number}, L1[23:0]);
    chk(access_abort, 1'b0);
    @(negedge core_clk);
    access_valid = 1'b0;
    cmd(8'h37, 8'h00, 8'h01, 48'h1000, PW, 2, 1'b1);
    cmd(8'h37, 8'h00, 8'h00, L3, PW, 2, 1'b0);
    chk(identify_words_103_100, {16'h0000, L3});
    chk({max_lba_nonvolatile, max_lba}, {1'b0, L3});
    chk(identify_words_61_60, L1[31:0]);
    cmd(8'h37, 8'h00, 8'h00, 48'h1_0000_0000, PW, 2, 1'b1);
    cmd(8'h37, 8'h00, 8'h00, L1, PW, 0, 1'b1);
    cmd(8'hF9, 8'h04, 8'h00, '0, PW, 0, 1'b0);
    chk(frozen, 1'b1);
    for (int f = 1; f < 4; f++) begin
      cmd(8'hF9, 8'(f), 8'h00, '0, PW, 0, 1'b1);
    end
    cmd(8'hF9, 8'h03, 8'h00, L1, PW, 1, 1'b1);
    chk({locked, unlock_tries_left, max_lba}, {4'h4, L3});
    do_reset();
    cmd(8'hF9, 8'h03, 8'h00, 48'h1234567, PW, 1, 1'b0);
    chk(max_lba, 48'h1234567);
    cmd(8'h37, 8'h00, 8'h00, L1, PW, 2, 1'b1);
    do_reset();
    address_offset_mode = 1'b1;
    cmd(8'h37, 8'h00, 8'h01, L1, PW, 2, 1'b1);
    address_offset_mode = 1'b0;
    for (int k = 4; k >= 0; k--) begin
      cmd(8'hF9, 8'h03, 8'h00, '0, ~PW, 0, 1'b1);
      chk(unlock_tries_left, k);
    end
    cmd(8'hF9, 8'h03, 8'h00, '0, PW, 0, 1'b1);
    complete_run();
  end
endmodule : max_address_security_control_tb_top
`default_nettype wire
